// ===== jrlx_top.sv
`timescale 1ns/1ps
// How it works
// RULE_01: Link 0 has a 6-bit writable delay from the multiframe clock to its local receiver, reset zero.
// RULE_02: Link 1 has its own 6-bit writable multiframe receiver delay, reset zero.
// RULE_03: Link 0 has a 6-bit writable buffer read-out delay in clock cycles, reset 0x3F.
// RULE_04: Link 1 has its own 6-bit writable buffer read-out delay, reset 0x3F.
// RULE_05: Software keeps each read-out delay at 0xC or below.
// RULE_06: A 3-bit field picks the physical lane for logical lane 1, reset physical lane 1.
// RULE_07: A 3-bit field picks the physical lane for logical lane 0, reset physical lane 0.
// RULE_08: A select code is a plain binary index of physical lanes 0 to 7.
// RULE_09: Link 1 settings act only in dual-link mode; in single-link mode only link 0 runs.
// RULE_10: Bits 7 and 6 of these registers read zero and ignore writes.
module jrlx_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lmfcPulse,
  input wire logic [jrlx_pkg::NUM_PHYS*jrlx_pkg::LANE_W-1:0] physLaneData,
  input wire logic [jrlx_pkg::NUM_PHYS-1:0] physLaneValid,
  output logic [jrlx_pkg::NUM_PHYS-1:0] physLaneReady,
  output logic [jrlx_pkg::LANE_W-1:0] logicalLane0Data,
  output logic logicalLane0Valid,
  input wire logic logicalLane0Ready,
  output logic [jrlx_pkg::LANE_W-1:0] logicalLane1Data,
  output logic logicalLane1Valid,
  input wire logic logicalLane1Ready,
  output logic lmfcRxLink0,
  output logic lmfcRxLink1
);
  import jrlx_pkg::*;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic regHit(input logic [31:0] addr, input logic [IDX_W-1:0] idx);
    regHit = (addr[31:12] == 20'h00000) && (addr[11:2] == idx);
  endfunction : regHit

  function automatic logic [LANE_W-1:0] laneOf(input logic [NUM_PHYS*LANE_W-1:0] bus, input logic [SEL_W-1:0] sel);
    laneOf = bus[sel*LANE_W +: LANE_W];
  endfunction : laneOf

  // ****************************************
  // Register bus slave
  // ****************************************
  logic awReady_r;
  logic wReady_r;
  logic [31:0] awAddr_r;
  logic [7:0] wByte_r;
  logic wLane0_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic arReady_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic [DLY_W-1:0] fcd_r [2];
  logic [DLY_W-1:0] brd_r [2];
  logic [SEL_W-1:0] sel0_r;
  logic [SEL_W-1:0] sel1_r;
  logic dual_r;
  logic realign_r;

  wire doWrite = !awReady_r && !wReady_r && !bValid_r;
  wire wrFcd0 = regHit(awAddr_r, IDX_FCD0);
  wire wrFcd1 = regHit(awAddr_r, IDX_FCD1);
  wire wrBrd0 = regHit(awAddr_r, IDX_BRD0);
  wire wrBrd1 = regHit(awAddr_r, IDX_BRD1);
  wire wrXbar = regHit(awAddr_r, IDX_XBAR);
  wire wrCtrl = regHit(awAddr_r, IDX_CTRL);
  wire wrMapped = wrFcd0 || wrFcd1 || wrBrd0 || wrBrd1 || wrXbar || wrCtrl || regHit(awAddr_r, IDX_STAT);
  wire wrEn = doWrite && wLane0_r;

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      awAddr_r <= 32'h00000000;
      wByte_r <= 8'h00;
      wLane0_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awReady_r) begin
        awReady_r <= 1'b0;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_r) begin
        wReady_r <= 1'b0;
        wByte_r <= s_axi_wdata[7:0];
        wLane0_r <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        bValid_r <= 1'b1;
        bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
        awReady_r <= 1'b1;
        wReady_r <= 1'b1;
      end
    end
  end

  // Only the low byte lane carries field bits, and bits 7 and 6 are never stored.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fcd_r[0] <= RST_FCD;
      fcd_r[1] <= RST_FCD;
      brd_r[0] <= RST_BRD;
      brd_r[1] <= RST_BRD;
      sel0_r <= RST_SEL0;
      sel1_r <= RST_SEL1;
      dual_r <= 1'b0;
      realign_r <= 1'b0;
    end else begin
      realign_r <= wrEn && wrCtrl && wByte_r[CTRL_REALIGN_BIT];
      if (wrEn && wrFcd0) begin
        fcd_r[0] <= wByte_r[DLY_W-1:0]; // see RULE_01 see RULE_10
      end
      if (wrEn && wrFcd1) begin
        fcd_r[1] <= wByte_r[DLY_W-1:0]; // see RULE_02 see RULE_10
      end
      if (wrEn && wrBrd0) begin
        brd_r[0] <= wByte_r[DLY_W-1:0]; // see RULE_03 see RULE_10
      end
      if (wrEn && wrBrd1) begin
        brd_r[1] <= wByte_r[DLY_W-1:0]; // see RULE_04 see RULE_10
      end
      if (wrEn && wrXbar) begin
        sel0_r <= wByte_r[SEL0_LSB +: SEL_W]; // see RULE_07
        sel1_r <= wByte_r[SEL1_LSB +: SEL_W]; // see RULE_06
      end
      if (wrEn && wrCtrl) begin
        dual_r <= wByte_r[CTRL_DUAL_BIT];
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  jrlx_align_t st_r [2];
  wire rel0 = (st_r[0] == ALIGN_DONE);
  wire rel1 = (st_r[1] == ALIGN_DONE);
  wire rdFcd0 = regHit(s_axi_araddr, IDX_FCD0);
  wire rdFcd1 = regHit(s_axi_araddr, IDX_FCD1);
  wire rdBrd0 = regHit(s_axi_araddr, IDX_BRD0);
  wire rdBrd1 = regHit(s_axi_araddr, IDX_BRD1);
  wire rdXbar = regHit(s_axi_araddr, IDX_XBAR);
  wire rdCtrl = regHit(s_axi_araddr, IDX_CTRL);
  wire rdStat = regHit(s_axi_araddr, IDX_STAT);
  wire rdMapped = rdFcd0 || rdFcd1 || rdBrd0 || rdBrd1 || rdXbar || rdCtrl || rdStat;
  wire [7:0] xbarVal = {2'b00, sel1_r, sel0_r};
  wire [7:0] statVal = {5'b00000, dual_r, rel1, rel0};
  wire [7:0] rdByte = rdFcd0 ? {2'b00, fcd_r[0]} :
                      rdFcd1 ? {2'b00, fcd_r[1]} :
                      rdBrd0 ? {2'b00, brd_r[0]} :
                      rdBrd1 ? {2'b00, brd_r[1]} :
                      rdXbar ? xbarVal :
                      rdCtrl ? {7'b0000000, dual_r} :
                      rdStat ? statVal : 8'h00; // see RULE_10

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arReady_r <= 1'b1;
      rValid_r <= 1'b0;
      rData_r <= 32'h00000000;
      rResp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && arReady_r) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b1;
      rData_r <= {24'h000000, rdByte};
      rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
      arReady_r <= 1'b1;
    end
  end

  // ****************************************
  // Multiframe receiver delay and buffer release
  // ****************************************
  logic [1:0] linkActive;
  logic [DLY_W-1:0] dlyCnt_r [2];
  logic [1:0] dlyRun_r;
  logic [1:0] lmfcRx_r;
  logic [DLY_W-1:0] varCnt_r [2];
  assign linkActive = {dual_r, 1'b1}; // see RULE_09
  assign lmfcRxLink0 = lmfcRx_r[0];
  assign lmfcRxLink1 = lmfcRx_r[1];

  // The read-out delay holds up to 63 cycles, but the lane buffer only bridges the documented range.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int l = 0; l < 2; l++) begin
        dlyCnt_r[l] <= '0;
        varCnt_r[l] <= '0;
        st_r[l] <= ALIGN_IDLE;
      end
      dlyRun_r <= 2'b00;
      lmfcRx_r <= 2'b00;
    end else begin
      for (int l = 0; l < 2; l++) begin
        lmfcRx_r[l] <= dlyRun_r[l] && (dlyCnt_r[l] == fcd_r[l]); // see RULE_01 see RULE_02
        if (!linkActive[l]) begin
          dlyRun_r[l] <= 1'b0;
        end else if (lmfcPulse) begin
          dlyRun_r[l] <= 1'b1;
          dlyCnt_r[l] <= '0;
        end else if (dlyRun_r[l]) begin
          dlyRun_r[l] <= (dlyCnt_r[l] != fcd_r[l]);
          dlyCnt_r[l] <= dlyCnt_r[l] + DLY_W'(1);
        end
        case (st_r[l])
          ALIGN_IDLE: begin
            if (linkActive[l] && lmfcRx_r[l]) begin
              st_r[l] <= ALIGN_WAIT;
              varCnt_r[l] <= '0;
            end
          end
          ALIGN_WAIT: begin
            varCnt_r[l] <= varCnt_r[l] + DLY_W'(1);
            if (varCnt_r[l] == brd_r[l]) begin
              st_r[l] <= ALIGN_DONE; // see RULE_03 see RULE_04 see RULE_05
            end
          end
          ALIGN_DONE: begin
            st_r[l] <= ALIGN_DONE;
          end
          default: begin
            st_r[l] <= ALIGN_IDLE;
          end
        endcase
        if (!linkActive[l] || realign_r) begin
          st_r[l] <= ALIGN_IDLE;
        end
      end
    end
  end

  // ****************************************
  // Lane crossbar and lane buffers
  // ****************************************
  wire lane1Rel = dual_r ? rel1 : rel0; // see RULE_09
  wire [LANE_W-1:0] xIn0 = laneOf(physLaneData, sel0_r); // see RULE_07 see RULE_08
  wire [LANE_W-1:0] xIn1 = laneOf(physLaneData, sel1_r); // see RULE_06 see RULE_08
  wire xVal0 = physLaneValid[sel0_r];
  wire xVal1 = physLaneValid[sel1_r];
  logic fifoRdy0;
  logic fifoRdy1;

  // Lanes that feed no logical lane are drained so an idle source never blocks.
  always_comb begin
    for (int p = 0; p < NUM_PHYS; p++) begin
      physLaneReady[p] = 1'b1;
      if (SEL_W'(p) == sel0_r && !fifoRdy0) begin
        physLaneReady[p] = 1'b0;
      end
      if (SEL_W'(p) == sel1_r && !fifoRdy1) begin
        physLaneReady[p] = 1'b0;
      end
    end
  end

  jrlx_fifo #(.W(LANE_W), .D(FIFO_DEPTH)) u_fifo0 (
    .clk(clk),
    .reset_n(reset_n),
    .flush(realign_r),
    .inData(xIn0),
    .inValid(xVal0 && physLaneReady[sel0_r]),
    .inReady(fifoRdy0),
    .readEn(rel0),
    .outData(logicalLane0Data),
    .outValid(logicalLane0Valid),
    .outReady(logicalLane0Ready)
  );

  jrlx_fifo #(.W(LANE_W), .D(FIFO_DEPTH)) u_fifo1 (
    .clk(clk),
    .reset_n(reset_n),
    .flush(realign_r),
    .inData(xIn1),
    .inValid(xVal1 && physLaneReady[sel1_r]),
    .inReady(fifoRdy1),
    .readEn(lane1Rel),
    .outData(logicalLane1Data),
    .outValid(logicalLane1Valid),
    .outReady(logicalLane1Ready)
  );
endmodule : jrlx_top

// ===== jrlx_pkg.sv
package jrlx_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int LANE_W = 32;
  localparam int NUM_PHYS = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int DLY_W = 6;
  localparam int SEL_W = 3;
  localparam int IDX_W = 10;
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_FCD0 = 10'h304;
  localparam logic [IDX_W-1:0] IDX_FCD1 = 10'h305;
  localparam logic [IDX_W-1:0] IDX_BRD0 = 10'h306;
  localparam logic [IDX_W-1:0] IDX_BRD1 = 10'h307;
  localparam logic [IDX_W-1:0] IDX_XBAR = 10'h308;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h30E;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h30F;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int SEL0_LSB = 0;
  localparam int SEL1_LSB = 3;
  localparam int CTRL_DUAL_BIT = 0;
  localparam int CTRL_REALIGN_BIT = 1;
  localparam int STAT_REL0_BIT = 0;
  localparam int STAT_REL1_BIT = 1;
  localparam int STAT_DUAL_BIT = 2;
  localparam logic [DLY_W-1:0] RST_FCD = 6'h00;
  localparam logic [DLY_W-1:0] RST_BRD = 6'h3F;
  localparam logic [DLY_W-1:0] BRD_MAX = 6'h0C;
  localparam logic [SEL_W-1:0] RST_SEL0 = 3'h0;
  localparam logic [SEL_W-1:0] RST_SEL1 = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum {ALIGN_IDLE, ALIGN_WAIT, ALIGN_DONE} jrlx_align_t;
endpackage : jrlx_pkg

// ===== jrlx_fifo.sv
`timescale 1ns/1ps
module jrlx_fifo #(
  parameter int W = 32,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic [W-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  input wire logic readEn,
  output logic [W-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic inReady_r;
  logic outValid_r;
  logic [W-1:0] outData_r;
  wire push = inValid && inReady_r;
  wire pop = readEn && (cnt_r != '0) && (!outValid_r || outReady);
  wire drain = outValid_r && outReady && !pop;
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign inReady = inReady_r;
  assign outValid = outValid_r;
  assign outData = outData_r;

  // A word popped from memory leaves the count, so the output stage adds one slot of slack.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
      inReady_r <= 1'b1;
      outValid_r <= 1'b0;
      outData_r <= '0;
    end else if (flush) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
      inReady_r <= 1'b1;
      outValid_r <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_r <= wrPtr_r + AW'(1);
      end
      if (pop) begin
        rdPtr_r <= rdPtr_r + AW'(1);
        outData_r <= mem[rdPtr_r];
        outValid_r <= 1'b1;
      end else if (drain) begin
        outValid_r <= 1'b0;
      end
      cnt_r <= cnt_nxt;
      inReady_r <= (cnt_nxt != (AW+1)'(D));
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule : jrlx_fifo

// ===== jrlx_top_assertions.sv
`timescale 1ns/1ps
module jrlx_top_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lmfcPulse,
  input wire logic [jrlx_pkg::LANE_W-1:0] logicalLane0Data,
  input wire logic logicalLane0Valid,
  input wire logic logicalLane0Ready,
  input wire logic lmfcRxLink0,
  input wire logic lmfcRxLink1
);
  import jrlx_pkg::*;
  // ********
  // Checks
  // ********
  // Cycles since the last boundary pulse, saturating so old pulses never excuse a late output.
  logic [6:0] since_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) since_r <= 7'h7F;
    else if (lmfcPulse) since_r <= 7'h00;
    else if (since_r != 7'h7F) since_r <= since_r + 7'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rx0_cause; lmfcRxLink0 |-> since_r inside {[7'h01:7'h40]}; endproperty
  a_rx0_cause: assert property (p_rx0_cause) else $error("link0 boundary without pulse");
  property p_rx1_cause; lmfcRxLink1 |-> since_r inside {[7'h01:7'h40]}; endproperty
  a_rx1_cause: assert property (p_rx1_cause) else $error("link1 boundary without pulse");
  property p_rdata_hi; s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0; endproperty
  a_rdata_hi: assert property (p_rdata_hi) else $error("upper read bits set");
  property p_unmapped; s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_b_answer; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write answer late");
  property p_b_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while answering");
  property p_lane_hold;
    logicalLane0Valid && !logicalLane0Ready |=> logicalLane0Valid && $stable(logicalLane0Data);
  endproperty
  a_lane_hold: assert property (p_lane_hold) else $error("lane0 word dropped");
endmodule : jrlx_top_checker
bind jrlx_top jrlx_top_checker chk (.clk, .reset_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .lmfcPulse, .logicalLane0Data, .logicalLane0Valid, .logicalLane0Ready, .lmfcRxLink0, .lmfcRxLink1);

// ===== jrlx_lane_source.sv
`timescale 1ns/1ps
module jrlx_lane_source (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [jrlx_pkg::NUM_PHYS-1:0] physLaneReady,
  output logic [jrlx_pkg::NUM_PHYS*jrlx_pkg::LANE_W-1:0] physLaneData,
  output logic [jrlx_pkg::NUM_PHYS-1:0] physLaneValid
);
  import jrlx_pkg::*;
  // ********
  // Counting source
  // ********
  // The top byte names the lane, so a crossbar slip shows in every word.
  logic [23:0] count_r [NUM_PHYS];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      physLaneValid <= '0;
      count_r <= '{default: 24'h0};
    end else begin
      for (int p = 0; p < NUM_PHYS; p++) begin
        if (physLaneValid[p] && physLaneReady[p]) count_r[p] <= count_r[p] + 24'h1;
        physLaneValid[p] <= run || (physLaneValid[p] && !physLaneReady[p]);
      end
    end
  end
  // An idle lane shows the inverse of its last word, never a stale copy.
  always_comb begin
    for (int p = 0; p < NUM_PHYS; p++) begin
      physLaneData[p*LANE_W +: LANE_W] = physLaneValid[p] ? {8'(p), count_r[p]} : ~{8'(p), count_r[p] - 24'h1};
    end
  end
endmodule : jrlx_lane_source

// ===== jrlx_top_bench.sv
`timescale 1ns/1ps
module jrlx_top_bench;
  import jrlx_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, lmfcPulse = 1'b0, run = 1'b0, hold = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [NUM_PHYS*LANE_W-1:0] physLaneData;
  logic [NUM_PHYS-1:0] physLaneValid, physLaneReady;
  logic [LANE_W-1:0] logicalLane0Data, logicalLane1Data;
  logic logicalLane0Valid, logicalLane1Valid, lmfcRxLink0, lmfcRxLink1;
  logic logicalLane0Ready = 1'b0, logicalLane1Ready = 1'b0;
  logic [2:0] exp0 = 3'h0, exp1 = 3'h1;
  logic [5:0] dl0, dl1, rb0, rb1;
  logic [IDX_W-1:0] regs [5];
  int fail_count = 0, num_checks = 0, cyc = 0, k0, k1, v0, v1, n, idle;
  jrlx_top dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lmfcPulse, .physLaneData,
    .physLaneValid, .physLaneReady, .logicalLane0Data, .logicalLane0Valid, .logicalLane0Ready, .logicalLane1Data,
    .logicalLane1Valid, .logicalLane1Ready, .lmfcRxLink0, .lmfcRxLink1);
  jrlx_lane_source src (.clk, .reset_n, .run, .physLaneReady, .physLaneData, .physLaneValid);
  // ********
  // Helpers
  // ********
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check
  function automatic logic [31:0] rst_val(input int j);
    rst_val = (j < 2) ? 32'(RST_FCD) : (j < 4) ? 32'(RST_BRD) : 32'({2'b00, RST_SEL1, RST_SEL0});
  endfunction : rst_val
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_axi_awaddr <= {20'h0, i, 2'b00};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [IDX_W-1:0] i, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= {20'h0, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  // One boundary pulse, then the edge counts at which each link answers and each lane starts.
  task automatic align(output int a0, output int a1, output int w0, output int w1);
    a0 = 0;
    a1 = 0;
    w0 = 0;
    w1 = 0;
    @(posedge clk) lmfcPulse <= 1'b1;
    @(posedge clk) lmfcPulse <= 1'b0;
    for (int k = 1; k < 90; k++) begin
      @(posedge clk);
      #1;
      if (lmfcRxLink0 === 1'b1) a0 = k;
      if (lmfcRxLink1 === 1'b1) a1 = k;
      if (logicalLane0Valid === 1'b1 && w0 == 0) w0 = k;
      if (logicalLane1Valid === 1'b1 && w1 == 0) w1 = k;
    end
  endtask : align
  always @(posedge clk) begin
    logicalLane0Ready <= !hold && $urandom_range(1) == 1;
    logicalLane1Ready <= !hold && $urandom_range(1) == 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      finish_test();
    end
    if (logicalLane0Valid === 1'b1 && logicalLane0Ready === 1'b1) check(logicalLane0Data[31:24], exp0, "lane0 src");
    if (logicalLane1Valid === 1'b1 && logicalLane1Ready === 1'b1) check(logicalLane1Data[31:24], exp1, "lane1 src");
  end
  // ********
  // Sequence
  // ********
  initial begin
    void'($urandom(32'h4305DDEF));
    regs = '{IDX_FCD0, IDX_FCD1, IDX_BRD0, IDX_BRD1, IDX_XBAR};
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    foreach (regs[j]) begin
      rd(regs[j], d, r);
      check(d, rst_val(j), "reset value");
      dl0 = (j == 2 || j == 3) ? 6'($urandom_range(12)) : 6'($urandom);
      wr(regs[j], {2'b11, dl0}, r);
      check(r, RESP_OKAY, "write resp");
      rd(regs[j], d, r);
      check(d, {26'h0, dl0}, "readback");
      check(r, RESP_OKAY, "read resp");
    end
    wr(10'h309, 8'h3F, r);
    check(r, RESP_SLVERR, "unmapped write");
    rd(10'h309, d, r);
    check(r, RESP_SLVERR, "unmapped read");
    check(d, 32'h0, "unmapped data");
    for (int c = 0; c < 8; c++) begin
      exp0 = 3'(c);
      exp1 = 3'(7 - c);
      dl0 = (c == 0) ? 6'h00 : 6'($urandom_range(40));
      dl1 = (c == 7) ? 6'h3F : 6'($urandom_range(40));
      rb0 = (c == 0) ? 6'h0C : 6'($urandom_range(12));
      rb1 = (c == 7) ? 6'h00 : 6'($urandom_range(12));
      wr(IDX_XBAR, {2'b11, exp1, exp0}, r);
      wr(IDX_FCD0, {2'b00, dl0}, r);
      wr(IDX_FCD1, {2'b00, dl1}, r);
      wr(IDX_BRD0, {2'b00, rb0}, r);
      wr(IDX_BRD1, {2'b00, rb1}, r);
      wr(IDX_CTRL, 8'h03, r);
      run <= 1'b1;
      hold <= 1'b1;
      align(k0, k1, v0, v1);
      check(k0, dl0 + 1, "link0 boundary");
      check(k1, dl1 + 1, "link1 boundary");
      check(v0 >= dl0 + rb0 + 3 && v0 <= dl0 + rb0 + 5, 1, "link0 release");
      check(v1 >= dl1 + rb1 + 3 && v1 <= dl1 + rb1 + 5, 1, "link1 release");
      check(physLaneReady[exp0], 0, "full buffer accepted");
      check(physLaneReady[3'(c + 2)], 1, "idle lane stalled");
      rd(IDX_STAT, d, r);
      check(d, 32'((1 << STAT_REL0_BIT) | (1 << STAT_REL1_BIT) | (1 << STAT_DUAL_BIT)), "dual status");
      hold <= 1'b0;
      repeat (30) @(posedge clk);
      run <= 1'b0;
      // A word can sit in a buffer while the output is briefly empty, so wait for a quiet stretch.
      n = 0;
      idle = 0;
      while (idle < 4 && n < 200) begin
        @(posedge clk);
        n++;
        idle = ((logicalLane0Valid | logicalLane1Valid | (|physLaneValid)) === 1'b0) ? idle + 1 : 0;
      end
      check(logicalLane0Valid | logicalLane1Valid, 0, "not drained");
    end
    wr(IDX_CTRL, 8'h02, r);
    align(k0, k1, v0, v1);
    check(k0, dl0 + 1, "single link0");
    check(k1, 0, "single link1");
    rd(IDX_STAT, d, r);
    check(d, 32'(1 << STAT_REL0_BIT), "single status");
    finish_test();
  end
endmodule : jrlx_top_bench
